// ==== ccl_consts.svh ====
// Offsets, field positions, read-only ones and key values of the configuration control block.
// Assumes it is included by bare name from the package and modules.
`ifndef CCL_CONSTS_SVH
`define CCL_CONSTS_SVH
`define CCL_ADDR_W 4
`define CCL_OFS_CONFIG 4'h0
`define CCL_OFS_UNLOCK 4'h1
`define CCL_OFS_PIN_SEL 4'h2
`define CCL_OFS_MOD_DIS 4'h3
`define CCL_BIT_PIN_LOCK 13
`define CCL_BIT_MOD_LOCK 12
`define CCL_BIT_DBG_EN 3
`define CCL_BIT_TDO_USE 0
`define CCL_RO_ONES 32'h0000_0006
// Key values are arbitrary
`define CCL_KEY1 32'h1357_2468
`define CCL_KEY2 32'h2468_1357
`endif

// ==== ccl_pkg.sv ====
// Types of the configuration control block.
// Assumes ccl_consts.svh is reachable by bare name.
`include "ccl_consts.svh"
package ccl_pkg;
	typedef struct packed {
		logic [`CCL_ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} ccl_req_t;
	typedef enum logic [1:0] {UNL_IDLE, UNL_HALF, UNL_OPEN} ccl_unl_st_t;
	typedef struct packed {
		ccl_unl_st_t st;
	} ccl_unl_state_t;
	typedef struct packed {
		logic pin_lock;
		logic mod_lock;
		logic dbg_en;
		logic tdo_use;
		logic [31:0] pin_sel;
		logic [31:0] mod_dis;
		logic [31:0] rdata;
	} ccl_state_t;
endpackage : ccl_pkg

// ==== ccl_unlock.sv ====
// Two-word unlock key detector for the lock bits.
// Assumes register strobes synchronous to core_clk.
`timescale 1ns/10ps
module ccl_unlock (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Key writes
	input wire logic key_wr,
	input wire logic [31:0] key_data,
	// Open state and consumption
	input wire logic consume,
	output logic open
);
	import ccl_pkg::*;
	ccl_unl_state_t s_q, s_d;
	always_comb begin
		s_d = s_q;
		if (consume) begin
			s_d.st = UNL_IDLE;
		end else if (key_wr) begin
			case (s_q.st)
				UNL_IDLE: s_d.st = (key_data == `CCL_KEY1) ? UNL_HALF : UNL_IDLE;
				UNL_HALF: s_d.st = (key_data == `CCL_KEY2) ? UNL_OPEN : UNL_IDLE;
				UNL_OPEN: s_d.st = UNL_OPEN;
				default: s_d.st = UNL_IDLE;
			endcase
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			s_q <= '{st: UNL_IDLE};
		end else begin
			s_q <= s_d;
		end
	end
	assign open = (s_q.st == UNL_OPEN);
endmodule : ccl_unlock

// ==== ccl_top.sv ====
// Configuration control register with lock bits guarding two register groups.
// Assumes a plain register port master; reads answer one cycle later.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "ccl_consts.svh"
module ccl_top (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Register port
	input wire ccl_pkg::ccl_req_t req,
	output logic [31:0] rdata,
	// Block controls
	output logic debug_port_enable,
	output logic two_wire_tdo_use,
	output logic [31:0] pin_select_regs,
	output logic [31:0] module_disable_regs
);
	import ccl_pkg::*;
	////////////////////////////////////////////////////////////////////////
	ccl_state_t s_q, s_d;
	logic open;
	logic cfg_wr;
	logic lock_change;
	logic key_wr;
	// Decode shared by the write guards and the checks
	function automatic logic wr_hit(input ccl_req_t r, input logic [`CCL_ADDR_W-1:0] ofs);
		return r.wr && (r.addr == ofs);
	endfunction : wr_hit
	function automatic logic rd_hit(input ccl_req_t r, input logic [`CCL_ADDR_W-1:0] ofs);
		return r.rd && (r.addr == ofs);
	endfunction : rd_hit
	function automatic logic [31:0] cfg_view(input ccl_state_t s);
		logic [31:0] v;
		v = `CCL_RO_ONES;
		v[`CCL_BIT_PIN_LOCK] = s.pin_lock;
		v[`CCL_BIT_MOD_LOCK] = s.mod_lock;
		v[`CCL_BIT_DBG_EN] = s.dbg_en;
		v[`CCL_BIT_TDO_USE] = s.tdo_use;
		return v;
	endfunction : cfg_view
	assign cfg_wr = wr_hit(req, `CCL_OFS_CONFIG);
	assign key_wr = wr_hit(req, `CCL_OFS_UNLOCK);
	assign lock_change = cfg_wr && ((req.wdata[`CCL_BIT_PIN_LOCK] != s_q.pin_lock)
		|| (req.wdata[`CCL_BIT_MOD_LOCK] != s_q.mod_lock));
	// One unlock buys one lock change
	ccl_unlock u_unlock (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.key_wr(key_wr),
		.key_data(req.wdata),
		.consume(lock_change && open),
		.open(open)
	);
	////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d = s_q;
		s_d.rdata = '0;
		if (cfg_wr) begin
			s_d.dbg_en = req.wdata[`CCL_BIT_DBG_EN];
			s_d.tdo_use = req.wdata[`CCL_BIT_TDO_USE];
			if (open) begin
				s_d.pin_lock = req.wdata[`CCL_BIT_PIN_LOCK];
				s_d.mod_lock = req.wdata[`CCL_BIT_MOD_LOCK];
			end
		end
		// Registered lock gates; a same-cycle lock write acts next cycle
		// pin-select write guard
		if (wr_hit(req, `CCL_OFS_PIN_SEL) && !s_q.pin_lock) begin
			s_d.pin_sel = req.wdata;
		end
		if (wr_hit(req, `CCL_OFS_MOD_DIS) && !s_q.mod_lock) begin
			s_d.mod_dis = req.wdata;
		end
		if (req.rd) begin
			case (req.addr)
				`CCL_OFS_CONFIG: s_d.rdata = cfg_view(s_q);
				`CCL_OFS_UNLOCK: s_d.rdata = {31'h0, open};
				`CCL_OFS_PIN_SEL: s_d.rdata = s_q.pin_sel;
				`CCL_OFS_MOD_DIS: s_d.rdata = s_q.mod_dis;
				default: s_d.rdata = '0;
			endcase
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			s_q.pin_lock <= 1'b0;
			s_q.mod_lock <= 1'b0;
			s_q.dbg_en <= 1'b1;
			s_q.tdo_use <= 1'b1;
			s_q.pin_sel <= 32'h0000_0000;
			s_q.mod_dis <= 32'h0000_0000;
			s_q.rdata <= 32'h0000_0000;
		end else begin
			s_q <= s_d;
		end
	end
	assign debug_port_enable = s_q.dbg_en;
	assign two_wire_tdo_use = s_q.tdo_use;
	assign pin_select_regs = s_q.pin_sel;
	assign module_disable_regs = s_q.mod_dis;
	assign rdata = s_q.rdata;
	////////////////////////////////////////////////////////////////////////
	// Read of the config view
	sequence s_cfg_read;
		rd_hit(req, `CCL_OFS_CONFIG);
	endsequence
	// Stray key write that sends the detector back to idle
	sequence s_key_reset;
		key_wr && (req.wdata != `CCL_KEY1) && (req.wdata != `CCL_KEY2) && !open;
	endsequence
	// Both keys on back-to-back cycles
	sequence s_key_pair;
		key_wr && (req.wdata == `CCL_KEY1) ##1 key_wr && (req.wdata == `CCL_KEY2);
	endsequence
	// Config write that spends the opening
	sequence s_lock_spend;
		open && lock_change;
	endsequence
	chk_pin_lock_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_q.pin_lock |=> $stable(pin_select_regs))
		else $error("pin-select changed while locked");
	chk_pin_write_lands: assert property (@(posedge core_clk) disable iff (!rst_b)
		wr_hit(req, `CCL_OFS_PIN_SEL) && !s_q.pin_lock |=> pin_select_regs == $past(req.wdata))
		else $error("pin-select write lost while unlocked");
	chk_pin_read: assert property (@(posedge core_clk) disable iff (!rst_b)
		rd_hit(req, `CCL_OFS_PIN_SEL) |=> rdata == $past(pin_select_regs))
		else $error("pin-select read wrong");
	chk_mod_lock_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_q.mod_lock |=> $stable(module_disable_regs))
		else $error("module-disable changed while locked");
	chk_mod_write_lands: assert property (@(posedge core_clk) disable iff (!rst_b)
		wr_hit(req, `CCL_OFS_MOD_DIS) && !s_q.mod_lock |=> module_disable_regs == $past(req.wdata))
		else $error("module-disable write lost while unlocked");
	chk_mod_read: assert property (@(posedge core_clk) disable iff (!rst_b)
		rd_hit(req, `CCL_OFS_MOD_DIS) |=> rdata == $past(module_disable_regs))
		else $error("module-disable read wrong");
	chk_lock_needs_key: assert property (@(posedge core_clk) disable iff (!rst_b)
		!open |=> $stable({s_q.pin_lock, s_q.mod_lock}))
		else $error("lock changed without unlock");
	chk_pair_opens: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_key_reset ##1 s_key_pair |=> open)
		else $error("key pair did not open");
	chk_open_spent: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_lock_spend |=> !open)
		else $error("opening not spent by lock change");
	chk_pin_lock_open: assert property (@(posedge core_clk) disable iff (!rst_b)
		cfg_wr && open |=> s_q.pin_lock == $past(req.wdata[`CCL_BIT_PIN_LOCK]))
		else $error("pin lock not written while open");
	chk_mod_lock_open: assert property (@(posedge core_clk) disable iff (!rst_b)
		cfg_wr && open |=> s_q.mod_lock == $past(req.wdata[`CCL_BIT_MOD_LOCK]))
		else $error("module lock not written while open");
	chk_key_readback: assert property (@(posedge core_clk) disable iff (!rst_b)
		rd_hit(req, `CCL_OFS_UNLOCK) |=> rdata == {31'h0, $past(open)})
		else $error("open state read wrong");
	chk_dbg_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
		cfg_wr |=> debug_port_enable == $past(req.wdata[`CCL_BIT_DBG_EN]))
		else $error("debug enable not written");
	chk_dbg_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		!cfg_wr |=> $stable(debug_port_enable))
		else $error("debug enable moved without write");
	chk_tdo_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
		cfg_wr |=> two_wire_tdo_use == $past(req.wdata[`CCL_BIT_TDO_USE]))
		else $error("tdo use not written");
	chk_tdo_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		!cfg_wr |=> $stable(two_wire_tdo_use))
		else $error("tdo use moved without write");
	chk_high_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_cfg_read |=> rdata[31:14] == 18'h0)
		else $error("upper bits not zero");
	chk_unmapped_read: assert property (@(posedge core_clk) disable iff (!rst_b)
		req.rd && (req.addr > `CCL_OFS_MOD_DIS) |=> rdata == '0)
		else $error("unmapped read not zero");
	chk_rdata_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
		!req.rd |=> rdata == '0)
		else $error("read data outside read cycle");
	chk_mid_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_cfg_read |=> rdata[11:4] == 8'h0)
		else $error("middle bits not zero");
	chk_ones_read: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_cfg_read |=> rdata[2:1] == 2'h3)
		else $error("bits two and one not one");
	chk_reset_vals: assert property (@(posedge core_clk)
		!rst_b |=> debug_port_enable && two_wire_tdo_use && !s_q.pin_lock && !s_q.mod_lock)
		else $error("reset values wrong");
	chk_reset_groups: assert property (@(posedge core_clk)
		!rst_b |=> pin_select_regs == '0 && module_disable_regs == '0 && rdata == '0)
		else $error("group reset values wrong");
endmodule : ccl_top

// ==== test_ccl_top.sv ====
// Self-checking bench for the configuration control register block.
// Assumes ccl_pkg and ccl_consts.svh are compiled ahead of this file.
`timescale 1ns/10ps
`include "ccl_consts.svh"
module test_ccl_top;
	import ccl_pkg::*;
	logic core_clk = 0;
	logic rst_b = 0;
	ccl_req_t req = '0;
	logic [31:0] rdata, pin, mod;
	logic dbg, tdo, rd_d = 0;
	logic pl = 0, ml = 0, db = 1, td = 1, op = 0, k1 = 0;
	logic [31:0] pm = '0, mm = '0;
	logic [97:0] q[$], e;
	int bad_count = 0, comparisons = 0, seed = 82963;
	ccl_top dut (.core_clk(core_clk), .rst_b(rst_b), .req(req), .rdata(rdata),
		.debug_port_enable(dbg), .two_wire_tdo_use(tdo), .pin_select_regs(pin),
		.module_disable_regs(mod));
	always #5 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////////////////////
	// Write, noting its effect in the bench's own view
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		// A wrong second key restarts; keys are ignored while open
		if (a == `CCL_OFS_UNLOCK && !op) begin
			op = k1 && d == `CCL_KEY2;
			k1 = !k1 && d == `CCL_KEY1;
		end
		if (a == `CCL_OFS_CONFIG) begin
			if (op && {d[13], d[12]} != {pl, ml}) begin
				{pl, ml} = {d[13], d[12]};
				op = 0;
			end
			db = d[3];
			td = d[0];
		end
		if (a == `CCL_OFS_PIN_SEL && !pl) pm = d;
		if (a == `CCL_OFS_MOD_DIS && !ml) mm = d;
	endtask : wr
	// Read, noting the expected view of the place read and of the block outputs
	task automatic rd(input logic [3:0] a);
		logic [31:0] x;
		@(posedge core_clk);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		case (a)
			`CCL_OFS_CONFIG: x = {18'h0, pl, ml, 8'h0, db, 2'h3, td};
			`CCL_OFS_UNLOCK: x = {31'h0, op};
			`CCL_OFS_PIN_SEL: x = pm;
			`CCL_OFS_MOD_DIS: x = mm;
			default: x = 32'h0;
		endcase
		q.push_back({x, db, td, pm, mm});
	endtask : rd
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////////////////
	// Monitor: read data stand only in the cycle after the strobe
	always @(posedge core_clk) rd_d <= req.rd;
	always @(negedge core_clk) begin
		if (rd_d) begin
			e = q.pop_front();
			comparisons++;
			if ({rdata, dbg, tdo, pin, mod} !== e) begin
				bad_count++;
				$display("[ERR] outputs exp %h got %h", e, {rdata, dbg, tdo, pin, mod});
			end
		end
	end
	initial begin
		#20000;
		bad_count++;
		wrap_up();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge core_clk);
		rst_b <= 1;
		rd(`CCL_OFS_CONFIG);
		$display("reset view done");
		wr(`CCL_OFS_CONFIG, 32'hFFFF_3000 | $random(seed));
		wr(`CCL_OFS_PIN_SEL, $random(seed));
		wr(`CCL_OFS_MOD_DIS, $random(seed));
		rd(`CCL_OFS_CONFIG);
		$display("keyless write done");
		wr(`CCL_OFS_UNLOCK, `CCL_KEY1);
		wr(`CCL_OFS_UNLOCK, `CCL_KEY2);
		wr(`CCL_OFS_CONFIG, 32'h0000_3009);
		wr(`CCL_OFS_PIN_SEL, $random(seed));
		wr(`CCL_OFS_MOD_DIS, $random(seed));
		rd(`CCL_OFS_CONFIG);
		wr(`CCL_OFS_CONFIG, 32'h0000_0000);
		rd(`CCL_OFS_CONFIG);
		$display("locked writes done");
		wr(`CCL_OFS_UNLOCK, `CCL_KEY1);
		wr(`CCL_OFS_UNLOCK, `CCL_KEY1);
		wr(`CCL_OFS_UNLOCK, `CCL_KEY2);
		wr(`CCL_OFS_CONFIG, 32'h0000_1008);
		wr(`CCL_OFS_PIN_SEL, $random(seed));
		wr(`CCL_OFS_MOD_DIS, $random(seed));
		rd(`CCL_OFS_CONFIG);
		wr(4'h5, $random(seed));
		rd(4'h5);
		$display("partial unlock done");
		wr(`CCL_OFS_UNLOCK, 32'h0000_0000);
		wr(`CCL_OFS_UNLOCK, `CCL_KEY1);
		wr(`CCL_OFS_UNLOCK, `CCL_KEY2);
		rd(`CCL_OFS_UNLOCK);
		wr(`CCL_OFS_CONFIG, 32'h0000_2001);
		rd(`CCL_OFS_UNLOCK);
		wr(`CCL_OFS_PIN_SEL, $random(seed));
		wr(`CCL_OFS_MOD_DIS, $random(seed));
		rd(`CCL_OFS_MOD_DIS);
		rd(`CCL_OFS_CONFIG);
		wr(`CCL_OFS_UNLOCK, `CCL_KEY1);
		wr(`CCL_OFS_UNLOCK, `CCL_KEY2);
		wr(`CCL_OFS_CONFIG, 32'h0000_0008);
		wr(`CCL_OFS_PIN_SEL, $random(seed));
		rd(`CCL_OFS_PIN_SEL);
		rd(`CCL_OFS_CONFIG);
		$display("single lock done");
		@(posedge core_clk);
		req <= '0;
		rst_b <= 0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1;
		{pl, ml, db, td, op, k1, pm, mm} = {4'h3, 2'h0, 64'h0};
		rd(`CCL_OFS_CONFIG);
		rd(`CCL_OFS_PIN_SEL);
		@(posedge core_clk);
		req <= '0;
		$display("mid-run reset done");
		repeat (4) @(posedge core_clk);
		wrap_up();
	end
endmodule : test_ccl_top
